//--- hdl/scc_coupler.sv
// smart card coupler control: serial port, data routing, pullup, alert, card clock
// assumes every input except rst and sub_address is asynchronous to clk and passes a two-stage synchroniser
`include "scc_params.svh"
`default_nettype none

module scc_coupler
  import scc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] sub_address,
  input  wire logic       cs_n,
  input  wire logic       spi_clk,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe_n,
  input  wire logic       line_pullup_select,
  output logic            line_pullup_on,
  input  wire logic       host_io_in,
  output logic            host_io_out,
  output logic            host_io_oe_n,
  input  wire logic       card_io_in,
  output logic            card_io_out,
  output logic            card_io_oe_n,
  input  wire logic       card_presence_input,
  input  wire logic       card_supply_overload,
  input  wire logic       supply_low,
  output logic            alert_n,
  input  wire logic       clk_in,
  output logic            card_clock_output
);

  scc_raw_t      raw;
  wire scc_raw_t sync2;
  wire scc_raw_t prev;

  assign raw = {clk_in, card_io_in, host_io_in, line_pullup_select, supply_low,
                card_supply_overload, card_presence_input, mosi, spi_clk};

  // two-stage synchronisers, third stage only for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      logic s1, s2, s3;
      always_ff @(posedge clk) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= raw[gi];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign sync2[gi] = s2;
      assign prev[gi]  = s3;
    end
  endgenerate

  logic cs_s1;
  logic cs_s;
  logic cs_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1   <= 1'b1;
      cs_s    <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_s1   <= cs_n;
      cs_s    <= cs_s1;
      cs_prev <= cs_s;
    end
  end

  logic spi_s, mosi_s, pres_s, ovl_s, low_s, pu_s, hio_s, cio_s, ck_s;
  assign {ck_s, cio_s, hio_s, pu_s, low_s, ovl_s, pres_s, mosi_s, spi_s} = sync2;

  logic spi_rise, spi_fall, cs_fall, ck_rise;
  assign spi_rise = spi_s & ~prev[0] & ~cs_s;
  assign spi_fall = ~spi_s & prev[0] & ~cs_s;
  assign cs_fall  = ~cs_s & cs_prev;
  assign ck_rise  = ck_s & ~prev[8];

  logic [7:0] shift, next_shift, status, shadow, next_shadow;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic       selected, next_selected;
  logic       sync_mode, next_sync_mode;
  logic       sync_data, next_sync_data;
  scc_div_t   div_sel, next_div_sel;
  logic       pending, next_pending;
  logic       next_alert_n, next_miso, next_pullup;
  logic       drv_host, next_drv_host, drv_card, next_drv_card;
  logic [1:0] guard, next_guard;
  logic       div_cnt, next_div_cnt, div_clk, next_div_clk, next_card_clk;
  logic       byte_done, addr_hit, clr_hit, xlat_en, sync_act, ev;

  assign status = {3'h0, pres_s, cio_s, ovl_s, pending, low_s};
  assign byte_done = spi_rise && bit_cnt == `SCC_BIT_CNT_LAST;
  assign addr_hit  = next_shift[`SCC_CMD_ADDR_HI:`SCC_CMD_ADDR_LO] == sub_address;
  assign clr_hit   = byte_done && addr_hit && next_shift[`SCC_CMD_CLEAR];
  assign xlat_en   = ~cs_s & selected & ~sync_mode;
  assign sync_act  = ~cs_s & selected & sync_mode;
  assign ev = (pres_s & ~prev[2]) | (~pres_s & prev[2]) | (ovl_s & ~prev[3]);

  always_comb begin
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_shadow    = shadow;
    next_miso      = miso;
    next_selected  = selected;
    next_sync_mode = sync_mode;
    next_sync_data = sync_data;
    next_div_sel   = div_sel;
    if (cs_s) begin
      next_bit_cnt  = 3'h0;
      next_selected = 1'b0;
    end else begin
      if (cs_fall) begin
        next_shadow = status;
        next_miso   = status[7];
      end
      if (spi_rise) begin
        next_shift   = {shift[6:0], mosi_s};
        next_bit_cnt = bit_cnt + 3'h1;
      end
      if (spi_fall) begin
        next_miso = shadow[3'h7 - bit_cnt];
      end
      if (byte_done) begin
        next_shadow   = status;
        next_selected = addr_hit;
        if (addr_hit) begin
          next_sync_mode = next_shift[`SCC_CMD_SYNC];
          next_sync_data = next_shift[`SCC_CMD_SDATA];
          case (next_shift[`SCC_CMD_DIV_HI:`SCC_CMD_DIV_LO])
            2'b01:   next_div_sel = SCC_DIV2;
            2'b10:   next_div_sel = SCC_DIV4;
            default: next_div_sel = SCC_DIV1;
          endcase
        end
      end
    end
    // event set wins over clear
    next_pending = ev | (pending & ~clr_hit);
    next_alert_n = low_s ? 1'b1 : ~next_pending;
    next_pullup  = ~cs_s & selected & pu_s;
    // translator: first side low owns the drive; own echo in the synchroniser masked after release
    next_drv_card = sync_act ? ~sync_data : (xlat_en & ~hio_s & ~drv_host & (drv_card | (guard == 2'h0)));
    next_drv_host = xlat_en & ~cio_s & ~drv_card & ~(~hio_s & ~drv_host) & (drv_host | (guard == 2'h0));
    next_guard    = (guard == 2'h0) ? 2'h0 : guard - 2'h1;
    if ((drv_card & ~next_drv_card) | (drv_host & ~next_drv_host)) begin
      next_guard = `SCC_ECHO_HOLD;
    end
    // card clock divider, toggles only on input clock rising edges
    next_div_cnt = div_cnt;
    next_div_clk = div_clk;
    if (ck_rise) begin
      next_div_cnt = ~div_cnt;
      if (div_sel == SCC_DIV2 || div_cnt) begin
        next_div_clk = ~div_clk;
      end
    end
    case (div_sel)
      SCC_DIV1: next_card_clk = ck_s;
      default:  next_card_clk = next_div_clk;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift             <= 8'h00;
      bit_cnt           <= 3'h0;
      shadow            <= 8'h00;
      miso              <= 1'b0;
      selected          <= 1'b0;
      sync_mode         <= 1'b0;
      sync_data         <= `SCC_RST_SDATA;
      div_sel           <= SCC_DIV1;
      pending           <= 1'b0;
      alert_n           <= `SCC_RST_ALERT_N;
      line_pullup_on    <= 1'b0;
      drv_card          <= 1'b0;
      drv_host          <= 1'b0;
      guard             <= 2'h0;
      div_cnt           <= 1'b0;
      div_clk           <= 1'b0;
      card_clock_output <= 1'b0;
    end else begin
      shift             <= next_shift;
      bit_cnt           <= next_bit_cnt;
      shadow            <= next_shadow;
      miso              <= next_miso;
      selected          <= next_selected;
      sync_mode         <= next_sync_mode;
      sync_data         <= next_sync_data;
      div_sel           <= next_div_sel;
      pending           <= next_pending;
      alert_n           <= next_alert_n;
      line_pullup_on    <= next_pullup;
      drv_card          <= next_drv_card;
      drv_host          <= next_drv_host;
      guard             <= next_guard;
      div_cnt           <= next_div_cnt;
      div_clk           <= next_div_clk;
      card_clock_output <= next_card_clk;
    end
  end

  assign miso_oe_n    = cs_s;
  assign host_io_out  = 1'b0;
  assign host_io_oe_n = ~drv_host;
  assign card_io_out  = 1'b0;
  assign card_io_oe_n = ~drv_card;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_xlat_off;
    (!xlat_en && !sync_act) |=> host_io_oe_n && card_io_oe_n;
  endproperty
  a_xlat_off: assert property (p_xlat_off) else $error("translator active while disabled");

  property p_sync_route;
    sync_act |=> host_io_oe_n && (card_io_oe_n == $past(sync_data));
  endproperty
  a_sync_route: assert property (p_sync_route) else $error("sync card data not routed");

  property p_pullup_sel;
    line_pullup_on |-> $past(selected) && $past(!cs_s);
  endproperty
  a_pullup_sel: assert property (p_pullup_sel) else $error("pullup on while unselected");

  property p_insert;
    $rose(pres_s) && !low_s |=> !alert_n;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion did not raise alert");

  property p_extract_ovl;
    ($fell(pres_s) || $rose(ovl_s)) && !low_s |=> !alert_n;
  endproperty
  a_extract_ovl: assert property (p_extract_ovl) else $error("extraction or overload missed");

  property p_low_force;
    low_s |=> alert_n;
  endproperty
  a_low_force: assert property (p_low_force) else $error("alert not forced high on low supply");

  property p_div_edges;
    (div_sel != SCC_DIV1) && (div_clk != $past(div_clk)) |-> $past(ck_rise);
  endproperty
  a_div_edges: assert property (p_div_edges) else $error("divided clock moved off input edge");

  property p_div1;
    (div_sel == SCC_DIV1) ##1 (div_sel == SCC_DIV1) |-> card_clock_output == $past(ck_s);
  endproperty
  a_div1: assert property (p_div1) else $error("undivided card clock wrong");

  property p_spi_clock;
    (shift != $past(shift)) |-> $past(spi_rise);
  endproperty
  a_spi_clock: assert property (p_spi_clock) else $error("shift moved without serial clock");

  property p_cs_off;
    cs_s |-> miso_oe_n ##1 (!selected && !line_pullup_on && host_io_oe_n && card_io_oe_n);
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("activity while chip select high");

  property p_hold;
    pending && !clr_hit |=> pending;
  endproperty
  a_hold: assert property (p_hold) else $error("alert dropped without clear");

  c_select: cover property (byte_done && addr_hit);
  c_clear:  cover property (clr_hit ##1 alert_n);
  c_div4:   cover property (div_sel == SCC_DIV4 && ck_rise);
  c_sync:   cover property (sync_act ##1 !card_io_oe_n);

endmodule
`default_nettype wire

//--- hdl/scc_params.svh
// offsets, field positions, reset values and timing counts of the coupler control
// assumes inclusion by bare name from the top module
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_CLK_HZ        50000000
`define SCC_SYNC_STAGES   2
`define SCC_BYTE_BITS     8
`define SCC_BIT_CNT_LAST  3'h7
`define SCC_ECHO_HOLD     2'h3
// command byte fields
`define SCC_CMD_ADDR_HI   7
`define SCC_CMD_ADDR_LO   6
`define SCC_CMD_DIV_HI    5
`define SCC_CMD_DIV_LO    4
`define SCC_CMD_SDATA     3
`define SCC_CMD_SYNC      2
`define SCC_CMD_CLEAR     1
// status byte fields, bits 7..5 read as zero
`define SCC_ST_PRESENT    4
`define SCC_ST_SDATA      3
`define SCC_ST_OVERLOAD   2
`define SCC_ST_ALERT      1
`define SCC_ST_LOWSUP     0
// reset values
`define SCC_RST_DIV       2'h0
`define SCC_RST_SDATA     1'h1
`define SCC_RST_ALERT_N   1'h1

`endif

//--- hdl/scc_pkg.sv
// types shared by the coupler control
// assumes scc_params.svh on the include path
`default_nettype none
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_DIV1 = 2'b00,
    SCC_DIV2 = 2'b01,
    SCC_DIV4 = 2'b10
  } scc_div_t;
  typedef logic [8:0] scc_raw_t;
endpackage
`default_nettype wire

//--- testbench/scc_host_model.sv
// host controller model: drives chip select and the serial port, collects the status byte
// assumes the caller enters its tasks at a falling clk edge
`default_nettype none
module scc_host_model (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output var  logic cs_n,
  output var  logic spi_clk,
  output var  logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 5;

  initial begin
    cs_n    = 1'b1;
    spi_clk = 1'b0;
    mosi    = 1'b0;
  end

  // one byte, msb first: address in 7:6 and the programming code below it
  task automatic xfer(input logic [7:0] cmd, input logic keep, output logic [7:0] st);
    int i;
    cs_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      mosi = cmd[i];
      repeat (HALF) @(negedge clk);
      st[i] = (miso_oe_n === 1'b0) ? miso : 1'bx;
      spi_clk = 1'b1;
      repeat (HALF) @(negedge clk);
      spi_clk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    st[7:5] = 3'h0;
    if (!keep) begin
      end_frame();
    end
  endtask

  // released data line shows the inverse of its last value
  task automatic end_frame();
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (HALF) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/scc_coupler_tb.sv
// self-checking bench of the coupler control
// assumes scc_host_model as the serial host; open-drain lines resolved here with pull-ups
`default_nettype none
module scc_coupler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ADDR = 2'h2;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs_n, spi_clk, mosi, miso, miso_oe_n;
  logic       line_pullup_select = 1'b1;
  logic       line_pullup_on, host_io_out, host_io_oe_n, card_io_out, card_io_oe_n;
  logic       host_low = 1'b0;
  logic       card_low = 1'b0;
  logic       card_presence_input = 1'b0;
  logic       card_supply_overload = 1'b0;
  logic       supply_low = 1'b0;
  logic       alert_n, card_clock_output;
  logic [3:0] ci_cnt = 4'h4;
  logic [7:0] st;
  int         num_errors = 0;
  int         checked = 0;

  wire host_io_in = !(host_low || host_io_oe_n === 1'b0);
  wire card_io_in = !(card_low || card_io_oe_n === 1'b0);
  wire clk_in     = (ci_cnt[3:2] == 2'h0);

  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) ci_cnt <= rst ? 4'h4 : ci_cnt + 4'h1;

  scc_host_model host (.clk(clk), .miso(miso), .miso_oe_n(miso_oe_n), .cs_n(cs_n), .spi_clk(spi_clk), .mosi(mosi));
  scc_coupler DUT (.clk(clk), .rst(rst), .sub_address(ADDR), .cs_n(cs_n), .spi_clk(spi_clk), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .line_pullup_select(line_pullup_select), .line_pullup_on(line_pullup_on),
    .host_io_in(host_io_in), .host_io_out(host_io_out), .host_io_oe_n(host_io_oe_n), .card_io_in(card_io_in),
    .card_io_out(card_io_out), .card_io_oe_n(card_io_oe_n), .card_presence_input(card_presence_input),
    .card_supply_overload(card_supply_overload), .supply_low(supply_low), .alert_n(alert_n), .clk_in(clk_in),
    .card_clock_output(card_clock_output));

  function automatic logic [7:0] mk(logic [1:0] a, logic [1:0] d, logic s, logic y, logic c);
    return {a, d, s, y, c, 1'b0};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic s_alert();
    card_presence_input = 1'b1;
    settle();
    chk("alert on insertion", 8'h00, {7'h0, alert_n});
    host.xfer(mk(~ADDR, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0, st);
    settle();
    chk("alert after foreign clear", 8'h00, {7'h0, alert_n});
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0, st);
    chk("status byte", 8'h1a, st);
    settle();
    chk("alert after clear", 8'h01, {7'h0, alert_n});
  endtask

  task automatic s_events();
    card_supply_overload = 1'b1;
    settle();
    chk("alert on overload", 8'h00, {7'h0, alert_n});
    supply_low = 1'b1;
    settle();
    chk("alert at low supply", 8'h01, {7'h0, alert_n});
    supply_low = 1'b0;
    settle();
    chk("alert after supply back", 8'h00, {7'h0, alert_n});
    card_supply_overload = 1'b0;
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0, st);
    card_presence_input = 1'b0;
    settle();
    chk("alert on extraction", 8'h00, {7'h0, alert_n});
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0, st);
    settle();
    chk("alert cleared again", 8'h01, {7'h0, alert_n});
  endtask

  task automatic s_route();
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b0, 1'b0), 1'b1, st);
    settle();
    chk("pullup when selected", 8'h01, {7'h0, line_pullup_on});
    host_low = 1'b1;
    settle();
    chk("host low to card", 8'h00, {6'h0, card_io_out, card_io_oe_n});
    host_low = 1'b0;
    settle();
    card_low = 1'b1;
    settle();
    chk("card low to host", 8'h00, {6'h0, host_io_out, host_io_oe_n});
    card_low = 1'b0;
    line_pullup_select = 1'b0;
    settle();
    chk("pullup deselected", 8'h00, {7'h0, line_pullup_on});
    line_pullup_select = 1'b1;
    host.end_frame();
    host_low = 1'b1;
    settle();
    chk("idle with select high", 8'h01, {6'h0, line_pullup_on, card_io_oe_n});
    host_low = 1'b0;
    host.xfer(mk(~ADDR, 2'h0, 1'b1, 1'b0, 1'b0), 1'b1, st);
    host_low = 1'b1;
    settle();
    chk("other coupler addressed", 8'h01, {6'h0, line_pullup_on, card_io_oe_n});
    host_low = 1'b0;
    host.end_frame();
  endtask

  task automatic s_sync();
    host.xfer(mk(ADDR, 2'h0, 1'b0, 1'b1, 1'b0), 1'b1, st);
    host_low = 1'b1;
    settle();
    chk("sync data low", 8'h02, {6'h0, host_io_oe_n, card_io_oe_n});
    host_low = 1'b0;
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b1, 1'b0), 1'b1, st);
    card_low = 1'b1;
    settle();
    chk("sync host released", 8'h03, {6'h0, host_io_oe_n, card_io_oe_n});
    host.end_frame();
    host.xfer(mk(ADDR, 2'h0, 1'b1, 1'b1, 1'b0), 1'b0, st);
    chk("sync card data in status", 8'h00, {7'h0, st[3]});
    card_low = 1'b0;
  endtask

  task automatic s_div();
    logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    int         hi [4]   = '{4, 16, 32, 4};
    int         lo [4]   = '{12, 16, 32, 12};
    int         i, n, h, l;
    for (i = 0; i < 4; i++) begin
      host.xfer(mk(ADDR, code[i], 1'b1, 1'b0, 1'b0), 1'b0, st);
      repeat (70) @(negedge clk);
      n = 0;
      while (card_clock_output !== 1'b0 && n < 100) begin @(negedge clk); n++; end
      while (card_clock_output !== 1'b1 && n < 200) begin @(negedge clk); n++; end
      h = 0;
      while (card_clock_output === 1'b1 && h < 100) begin @(negedge clk); h++; end
      l = 0;
      while (card_clock_output === 1'b0 && l < 100) begin @(negedge clk); l++; end
      chk("card clock high", 8'(hi[i]), 8'(h));
      chk("card clock low", 8'(lo[i]), 8'(l));
    end
  endtask

  initial begin
    #500000;
    num_errors++;
    $display("CHECK FAILED watchdog expected finished seen timeout");
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("reset outputs", 8'h36, {1'h0, miso, miso_oe_n, alert_n, line_pullup_on, host_io_oe_n, card_io_oe_n,
      card_clock_output});
    s_alert();
    s_events();
    s_route();
    s_sync();
    s_div();
    print_verdict();
  end
endmodule
`default_nettype wire
